// [pif_regs.vh]
// register offsets, field positions and reset values of the
// peripheral interrupt request flag block.
// assumes byte-wide registers on a plain strobe port.
`ifndef PIF_REGS_VH
`define PIF_REGS_VH

// ------------------------------------------------------------
// register offsets on the plain port
// ------------------------------------------------------------
`define PIF_ADDR_W 4
`define PIF_OFS_REQ2 4'h0
`define PIF_OFS_REQ3 4'h1
`define PIF_OFS_REQ4 4'h2

// ------------------------------------------------------------
// reset values and implemented-bit masks
// ------------------------------------------------------------
`define PIF_RST_REQ2 8'h00
`define PIF_RST_REQ3 8'h00
`define PIF_RST_REQ4 8'h00
`define PIF_IMPL_REQ2 8'hf3
`define PIF_IMPL_REQ3 8'hff
`define PIF_IMPL_REQ4 8'hff

// ------------------------------------------------------------
// field positions, request register 2
// ------------------------------------------------------------
`define PIF_R2_TIMER6_MATCH 7
`define PIF_R2_COMPARATOR2 6
`define PIF_R2_COMPARATOR1 5
`define PIF_R2_NONVOLATILE_DONE 4
`define PIF_R2_TIMER4_MATCH 1
`define PIF_R2_ACCUM_ROLLOVER 0

// ------------------------------------------------------------
// field positions, request registers 3 and 4
// ------------------------------------------------------------
`define PIF_R3_OSC_FAIL 7
`define PIF_R3_CLOCK_SWITCH 6
`define PIF_R3_TIMER3_GATE 5
`define PIF_R3_TIMER3_OVF 4
`define PIF_R4_WAVEGEN2 7
`define PIF_R4_WAVEGEN1 6
`define PIF_R4_TIMER5_GATE 5
`define PIF_R4_TIMER5_OVF 4

// ------------------------------------------------------------
// capture/compare/pwm mode codes, two bits per unit
// ------------------------------------------------------------
`define PIF_MODE_OFF 2'h0
`define PIF_MODE_CAPTURE 2'h1
`define PIF_MODE_COMPARE 2'h2
`define PIF_MODE_PWM 2'h3

`endif

// [pif_edge_det.v]
// edge detector for a vector of level-type event sources.
// assumes the levels come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module pif_edge_det #(
  parameter W = 9
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] level_in,
  output reg [W-1:0] rise_out,
  output reg [W-1:0] fall_out
);

  reg [W-1:0] prev_r;

  // ------------------------------------------------------------
  // remember last level, flag edges for one cycle
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      prev_r <= {W{1'b0}};
      rise_out <= {W{1'b0}};
      fall_out <= {W{1'b0}};
    end else begin
      prev_r <= level_in;
      rise_out <= level_in & ~prev_r;
      fall_out <= prev_r & ~level_in;
    end
  end

endmodule // pif_edge_det

`default_nettype wire

// [pif_ccp_sel.v]
// mode-dependent event select for four capture/compare/pwm units.
// assumes mode and events come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.vh"

module pif_ccp_sel (
  input wire [7:0] capcmp_mode_select,
  input wire [3:0] capture_evt,
  input wire [3:0] compare_evt,
  input wire [3:0] pwm_fall,
  output reg [3:0] unit_set
);

  // picks the one event that counts in the unit's mode
  function pick;
    input [1:0] mode;
    input cap;
    input cmp;
    input pwm;
    begin
      case (mode)
        `PIF_MODE_CAPTURE: pick = cap;
        `PIF_MODE_COMPARE: pick = cmp;
        `PIF_MODE_PWM: pick = pwm;
        default: pick = 1'b0;
      endcase
    end
  endfunction

  integer i;

  // ------------------------------------------------------------
  // per-unit selection
  // ------------------------------------------------------------
  always @* begin
    unit_set = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      unit_set[i] = pick(capcmp_mode_select[2*i +: 2], capture_evt[i],
        compare_evt[i], pwm_fall[i]);
    end
  end

endmodule // pif_ccp_sel

`default_nettype wire

// [pif_flag_regs.v]
// peripheral interrupt request flag registers 2, 3 and 4.
// assumes on-chip peripherals on clk drive one-cycle event pulses
// or levels, and the cpu uses the plain strobe register port.
//
// Overview of operation
// RULE_01: flags set regardless of any enable
// RULE_02: software clears stale flags before enabling
// RULE_03: register 2 bits 3-2 read zero, ignore writes
// RULE_04: flags read/write, hardware set, reset zero
// RULE_05: timer 6 period match sets reg2 bit7
// RULE_06: comparators 2,1 set reg2 bits 6,5
// RULE_07: memory programming done sets reg2 bit4
// RULE_08: timer 4 period match sets reg2 bit1
// RULE_09: oscillator accumulator rollover sets reg2 bit0
// RULE_10: oscillator failure sets reg3 bit7
// RULE_11: clock switch done sets reg3 bit6
// RULE_12: timer 3 gate closing sets reg3 bit5
// RULE_13: timer 3 overflow sets reg3 bit4
// RULE_14: logic cells 4..1 set reg3 bits 3..0
// RULE_15: waveform generators 2,1 shutdown set reg4 bits 7,6
// RULE_16: timer 5 gate closing sets reg4 bit5
// RULE_17: timer 5 overflow sets reg4 bit4
// RULE_18: units 4,3 set reg4 bits 3,2 by mode
// RULE_19: units 2,1 set reg4 bits 1,0 by mode
// RULE_20: hardware set beats same-cycle software clear
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.vh"

module pif_flag_regs (
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [`PIF_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // request register 2 sources, one-cycle pulses
  input wire timer6_match_evt,
  input wire comparator2_evt,
  input wire comparator1_evt,
  input wire nonvolatile_done_evt,
  input wire timer4_match_evt,
  input wire oscillator_accum_rollover_evt,
  // request register 3 sources
  input wire oscillator_fail_lvl,
  input wire clock_switch_done_evt,
  input wire timer3_gate_lvl,
  input wire timer3_overflow_evt,
  input wire [3:0] logic_cell_irq_evt,
  // request register 4 sources
  input wire [1:0] waveform_gen_shutdown_lvl,
  input wire timer5_gate_lvl,
  input wire timer5_overflow_evt,
  input wire [7:0] capcmp_mode_select,
  input wire [3:0] capcmp_capture_evt,
  input wire [3:0] capcmp_compare_evt,
  input wire [3:0] capcmp_pwm_out,
  // flag values towards the enable and priority logic
  output reg [7:0] periph_irq_request_2,
  output reg [7:0] periph_irq_request_3,
  output reg [7:0] periph_irq_request_4
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // next flag value: software value where written, then or-in
  // the hardware sets so a same-cycle event is never lost
  function [7:0] flag_next;
    input [7:0] cur;
    input hit;
    input [7:0] wdata;
    input [7:0] hw_set;
    input [7:0] impl;
    reg [7:0] base;
    begin
      base = hit ? wdata : cur;
      flag_next = (base | hw_set) & impl; // RULE_20
    end
  endfunction

  // address match for a write or read strobe
  function hit_of;
    input strobe;
    input [`PIF_ADDR_W-1:0] addr;
    input [`PIF_ADDR_W-1:0] ofs;
    begin
      hit_of = strobe && (addr == ofs);
    end
  endfunction

  // ------------------------------------------------------------
  // level sources turned into edge pulses
  // ------------------------------------------------------------

  // bit order: pwm outputs 3..0, wavegen 2..1, timer5 gate,
  // timer3 gate, oscillator fail
  wire [8:0] lvl_vec;
  wire [8:0] lvl_rise;
  wire [8:0] lvl_fall;

  assign lvl_vec = {capcmp_pwm_out, waveform_gen_shutdown_lvl,
    timer5_gate_lvl, timer3_gate_lvl, oscillator_fail_lvl};

  pif_edge_det #(
    .W(9)
  ) u_edges (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(lvl_vec),
    .rise_out(lvl_rise),
    .fall_out(lvl_fall)
  );

  // named edge events
  wire osc_fail_set;
  wire timer3_gate_set;
  wire timer5_gate_set;
  wire [1:0] wavegen_set;
  wire [3:0] pwm_trail_set;

  assign osc_fail_set = lvl_rise[0]; // RULE_10
  assign timer3_gate_set = lvl_fall[1]; // RULE_12
  assign timer5_gate_set = lvl_fall[2]; // RULE_16
  assign wavegen_set = lvl_rise[4:3]; // RULE_15
  assign pwm_trail_set = lvl_fall[8:5];

  // ------------------------------------------------------------
  // capture/compare/pwm event selection by mode
  // ------------------------------------------------------------
  wire [3:0] capcmp_set;

  pif_ccp_sel u_ccp_sel (
    .capcmp_mode_select(capcmp_mode_select),
    .capture_evt(capcmp_capture_evt),
    .compare_evt(capcmp_compare_evt),
    .pwm_fall(pwm_trail_set),
    .unit_set(capcmp_set)
  );

  // ------------------------------------------------------------
  // hardware set vector, request register 2
  // ------------------------------------------------------------

  // no enable input exists here, so sets cannot be gated
  reg [7:0] set2;

  always @* begin
    set2 = 8'h00; // RULE_01
    set2[`PIF_R2_TIMER6_MATCH] = timer6_match_evt; // RULE_05
    set2[`PIF_R2_COMPARATOR2] = comparator2_evt; // RULE_06
    set2[`PIF_R2_COMPARATOR1] = comparator1_evt; // RULE_06
    set2[`PIF_R2_NONVOLATILE_DONE] = nonvolatile_done_evt; // RULE_07
    set2[`PIF_R2_TIMER4_MATCH] = timer4_match_evt; // RULE_08
    set2[`PIF_R2_ACCUM_ROLLOVER] = oscillator_accum_rollover_evt; // RULE_09
  end

  // ------------------------------------------------------------
  // hardware set vector, request register 3
  // ------------------------------------------------------------
  reg [7:0] set3;

  always @* begin
    set3 = 8'h00;
    set3[`PIF_R3_OSC_FAIL] = osc_fail_set; // RULE_10
    set3[`PIF_R3_CLOCK_SWITCH] = clock_switch_done_evt; // RULE_11
    set3[`PIF_R3_TIMER3_GATE] = timer3_gate_set; // RULE_12
    set3[`PIF_R3_TIMER3_OVF] = timer3_overflow_evt; // RULE_13
    set3[3:0] = logic_cell_irq_evt; // RULE_14
  end

  // ------------------------------------------------------------
  // hardware set vector, request register 4
  // ------------------------------------------------------------
  reg [7:0] set4;

  always @* begin
    set4 = 8'h00;
    set4[`PIF_R4_WAVEGEN2] = wavegen_set[1]; // RULE_15
    set4[`PIF_R4_WAVEGEN1] = wavegen_set[0]; // RULE_15
    set4[`PIF_R4_TIMER5_GATE] = timer5_gate_set; // RULE_16
    set4[`PIF_R4_TIMER5_OVF] = timer5_overflow_evt; // RULE_17
    set4[3:2] = capcmp_set[3:2]; // RULE_18
    set4[1:0] = capcmp_set[1:0]; // RULE_19
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  wire wr_req2;
  wire wr_req3;
  wire wr_req4;

  assign wr_req2 = hit_of(reg_wr, reg_addr, `PIF_OFS_REQ2);
  assign wr_req3 = hit_of(reg_wr, reg_addr, `PIF_OFS_REQ3);
  assign wr_req4 = hit_of(reg_wr, reg_addr, `PIF_OFS_REQ4);

  // ------------------------------------------------------------
  // next flag values
  // ------------------------------------------------------------
  wire [7:0] req2_nxt;
  wire [7:0] req3_nxt;
  wire [7:0] req4_nxt;

  // unimplemented bits of register 2 are masked out here
  assign req2_nxt = flag_next(periph_irq_request_2, wr_req2,
    reg_wdata, set2, `PIF_IMPL_REQ2); // RULE_03
  assign req3_nxt = flag_next(periph_irq_request_3, wr_req3,
    reg_wdata, set3, `PIF_IMPL_REQ3); // RULE_04
  assign req4_nxt = flag_next(periph_irq_request_4, wr_req4,
    reg_wdata, set4, `PIF_IMPL_REQ4); // RULE_04

  // ------------------------------------------------------------
  // flag registers
  // ------------------------------------------------------------

  // flags hold until software writes a zero; any reset clears
  always @(posedge clk) begin
    if (sys_rst) begin
      periph_irq_request_2 <= `PIF_RST_REQ2; // RULE_04
      periph_irq_request_3 <= `PIF_RST_REQ3; // RULE_04
      periph_irq_request_4 <= `PIF_RST_REQ4; // RULE_04
    end else begin
      periph_irq_request_2 <= req2_nxt;
      periph_irq_request_3 <= req3_nxt;
      periph_irq_request_4 <= req4_nxt;
    end
  end

  // ------------------------------------------------------------
  // field view of the flags
  // ------------------------------------------------------------

  // one named wire per flag; the read path is built from these,
  // so the empty holes of register 2 are tied off by shape
  // register 2 fields
  wire timer6_match_flag;
  wire comparator2_flag;
  wire comparator1_flag;
  wire nonvolatile_done_flag;
  wire timer4_match_flag;
  wire oscillator_accum_rollover_flag;

  // register 3 fields
  wire oscillator_fail_flag;
  wire clock_switch_done_flag;
  wire timer3_gate_flag;
  wire timer3_overflow_flag;
  wire logic_cell4_flag;
  wire logic_cell3_flag;
  wire logic_cell2_flag;
  wire logic_cell1_flag;

  // register 4 fields
  wire waveform_gen2_shutdown_flag;
  wire waveform_gen1_shutdown_flag;
  wire timer5_gate_flag;
  wire timer5_overflow_flag;
  wire capcmp_unit4_flag;
  wire capcmp_unit3_flag;
  wire capcmp_unit2_flag;
  wire capcmp_unit1_flag;

  // register 2 field taps
  assign timer6_match_flag = periph_irq_request_2[`PIF_R2_TIMER6_MATCH];
  assign comparator2_flag = periph_irq_request_2[`PIF_R2_COMPARATOR2];
  assign comparator1_flag = periph_irq_request_2[`PIF_R2_COMPARATOR1];
  assign nonvolatile_done_flag =
    periph_irq_request_2[`PIF_R2_NONVOLATILE_DONE];
  assign timer4_match_flag = periph_irq_request_2[`PIF_R2_TIMER4_MATCH];
  assign oscillator_accum_rollover_flag =
    periph_irq_request_2[`PIF_R2_ACCUM_ROLLOVER];

  // register 3 field taps
  assign oscillator_fail_flag = periph_irq_request_3[`PIF_R3_OSC_FAIL];
  assign clock_switch_done_flag = periph_irq_request_3[`PIF_R3_CLOCK_SWITCH];
  assign timer3_gate_flag = periph_irq_request_3[`PIF_R3_TIMER3_GATE];
  assign timer3_overflow_flag = periph_irq_request_3[`PIF_R3_TIMER3_OVF];
  assign logic_cell4_flag = periph_irq_request_3[3];
  assign logic_cell3_flag = periph_irq_request_3[2];
  assign logic_cell2_flag = periph_irq_request_3[1];
  assign logic_cell1_flag = periph_irq_request_3[0];

  // register 4 field taps
  assign waveform_gen2_shutdown_flag = periph_irq_request_4[`PIF_R4_WAVEGEN2];
  assign waveform_gen1_shutdown_flag = periph_irq_request_4[`PIF_R4_WAVEGEN1];
  assign timer5_gate_flag = periph_irq_request_4[`PIF_R4_TIMER5_GATE];
  assign timer5_overflow_flag = periph_irq_request_4[`PIF_R4_TIMER5_OVF];
  assign capcmp_unit4_flag = periph_irq_request_4[3];
  assign capcmp_unit3_flag = periph_irq_request_4[2];
  assign capcmp_unit2_flag = periph_irq_request_4[1];
  assign capcmp_unit1_flag = periph_irq_request_4[0];

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  reg [7:0] rdata_nxt;

  // data valid the cycle after the strobe only, zero otherwise;
  // unmapped offsets read as zero
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PIF_OFS_REQ2: begin
          rdata_nxt = {timer6_match_flag, comparator2_flag,
            comparator1_flag, nonvolatile_done_flag, 2'b00,
            timer4_match_flag, oscillator_accum_rollover_flag}; // RULE_03
        end
        `PIF_OFS_REQ3: begin
          rdata_nxt = {oscillator_fail_flag, clock_switch_done_flag,
            timer3_gate_flag, timer3_overflow_flag, logic_cell4_flag,
            logic_cell3_flag, logic_cell2_flag, logic_cell1_flag};
        end
        `PIF_OFS_REQ4: begin
          rdata_nxt = {waveform_gen2_shutdown_flag,
            waveform_gen1_shutdown_flag, timer5_gate_flag,
            timer5_overflow_flag, capcmp_unit4_flag, capcmp_unit3_flag,
            capcmp_unit2_flag, capcmp_unit1_flag};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule // pif_flag_regs

`default_nettype wire

// [pif_flag_regs_props.sv]
// checker for the flag registers, watching the top module's ports only.
// assumes synchronous active-high reset and one-cycle register strobes.
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.vh"

module pif_flag_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`PIF_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer6_match_evt,
  input wire logic oscillator_fail_lvl,
  input wire logic timer3_overflow_evt,
  input wire logic timer5_gate_lvl,
  input wire logic [7:0] capcmp_mode_select,
  input wire logic [3:0] capcmp_capture_evt,
  input wire logic [3:0] capcmp_compare_evt,
  input wire logic [7:0] periph_irq_request_2,
  input wire logic [7:0] periph_irq_request_3,
  input wire logic [7:0] periph_irq_request_4
);
  // ------------------------------------------------------------
  // flag and read port properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_unimpl_zero: assert property (periph_irq_request_2[3:2] == 2'b00)
    else $error("request 2 bits 3-2 not zero");
  a_read_req3: assert property (reg_rd && reg_addr == `PIF_OFS_REQ3 |=>
    reg_rdata == $past(periph_irq_request_3)) else $error("bad read data");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_t6_sets: assert property (timer6_match_evt |=> periph_irq_request_2[7])
    else $error("timer 6 match flag not set");
  a_t4_holds: assert property (periph_irq_request_2[1] &&
    !(reg_wr && reg_addr == `PIF_OFS_REQ2) |=> periph_irq_request_2[1])
    else $error("timer 4 flag dropped without write");
  a_osc_fail_sets: assert property ($rose(oscillator_fail_lvl) |->
    ##[1:2] periph_irq_request_3[7]) else $error("osc fail flag not set");
  a_t3ovf_sets: assert property (timer3_overflow_evt |=>
    periph_irq_request_3[4]) else $error("timer 3 overflow flag not set");
  a_t5gate_sets: assert property ($fell(timer5_gate_lvl) |->
    ##[1:2] periph_irq_request_4[5]) else $error("timer 5 gate flag not set");
  a_cmp4_sets: assert property (capcmp_compare_evt[3] &&
    capcmp_mode_select[7:6] == `PIF_MODE_COMPARE |=> periph_irq_request_4[3])
    else $error("unit 4 compare flag not set");
  a_cap1_sets: assert property (capcmp_capture_evt[0] &&
    capcmp_mode_select[1:0] == `PIF_MODE_CAPTURE |=> periph_irq_request_4[0])
    else $error("unit 1 capture flag not set");
  a_set_wins: assert property (reg_wr && reg_addr == `PIF_OFS_REQ3 &&
    timer3_overflow_evt |=> periph_irq_request_3[4])
    else $error("clear beat a same-cycle set");
endmodule // pif_flag_regs_chk

bind pif_flag_regs pif_flag_regs_chk u_chk (.clk, .sys_rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .timer6_match_evt, .oscillator_fail_lvl,
  .timer3_overflow_evt, .timer5_gate_lvl, .capcmp_mode_select,
  .capcmp_capture_evt, .capcmp_compare_evt, .periph_irq_request_2,
  .periph_irq_request_3, .periph_irq_request_4);
`default_nettype wire

// [pif_src_model.sv]
// model of the on-chip peripherals: event pulses and source levels.
// assumes one caller per task at a time, all on the system clock.
`timescale 1ns/100ps
`default_nettype none

module pif_src_model (
  input wire logic clk,
  output var logic [20:0] p,
  output var logic [8:0] l,
  output var logic [7:0] mode
);
  // idle: gates open, pwm outputs high, no events, units off
  initial begin
    p = 21'h0;
    l = 9'h1f2;
    mode = 8'h00;
  end
  // one-cycle event pulse on the chosen sources
  task automatic pulse(input logic [20:0] m);
    @(posedge clk);
    p <= m;
    @(posedge clk);
    p <= 21'h0;
  endtask
  // toggle one level source
  task automatic flip(input int i);
    @(posedge clk);
    l <= l ^ (9'h1 << i);
  endtask
  task automatic set_mode(input logic [7:0] m);
    @(posedge clk);
    mode <= m;
  endtask
endmodule // pif_src_model
`default_nettype wire

// [pif_flag_regs_bench.sv]
// self-checking bench for the flag registers.
// assumes the source model drives every event input.
`timescale 1ns/100ps
`default_nettype none
`include "pif_regs.vh"

module pif_flag_regs_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata, r2, r3, r4, v;
  logic [20:0] p;
  logic [8:0] l;
  logic [7:0] mode;
  logic [23:0] fl;
  int err_total = 0;
  int num_checks = 0;
  int pos[21] = '{0,1,4,5,6,7,8,9,10,11,12,14,20,16,17,18,19,16,17,18,19};
  int lpos[9] = '{15,13,22,23,21,16,17,18,19};
  logic [7:0] imp[4] = '{`PIF_IMPL_REQ2, `PIF_IMPL_REQ3, `PIF_IMPL_REQ4, 8'h00};
  logic [7:0] md[4] = '{8'h00, 8'h55, 8'haa, 8'he4};
  logic [20:0] pm[4] = '{21'h1fe000, 21'h1e0000, 21'h01e000, 21'h1fe000};
  logic [23:0] ex[4] = '{24'h0, 24'h0, 24'h0, 24'h060000};

  assign fl = {r4, r3, r2};
  initial forever #12.5 clk = ~clk;

  pif_src_model u_src (.clk(clk), .p(p), .l(l), .mode(mode));
  pif_flag_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .timer6_match_evt(p[5]), .comparator2_evt(p[4]),
    .comparator1_evt(p[3]), .nonvolatile_done_evt(p[2]),
    .timer4_match_evt(p[1]), .oscillator_accum_rollover_evt(p[0]),
    .oscillator_fail_lvl(l[0]), .clock_switch_done_evt(p[11]),
    .timer3_gate_lvl(l[1]), .timer3_overflow_evt(p[10]),
    .logic_cell_irq_evt(p[9:6]), .waveform_gen_shutdown_lvl(l[3:2]),
    .timer5_gate_lvl(l[4]), .timer5_overflow_evt(p[12]),
    .capcmp_mode_select(mode), .capcmp_capture_evt(p[16:13]),
    .capcmp_compare_evt(p[20:17]), .capcmp_pwm_out(l[8:5]),
    .periph_irq_request_2(r2), .periph_irq_request_3(r3),
    .periph_irq_request_4(r4));

  // ------------------------------------------------------------
  // bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clr;
    wr(`PIF_OFS_REQ2, 8'h00);
    wr(`PIF_OFS_REQ3, 8'h00);
    wr(`PIF_OFS_REQ4, 8'h00);
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkf(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], v);
      chk8("reset read", 8'h00, v);
    end
    $display("test reset values done");
    for (int a = 0; a < 4; a++) begin
      wr(a[3:0], 8'hff);
      rd(a[3:0], v);
      chk8("write ones read", imp[a], v);
    end
    clr;
    cyc(1);
    chkf("cleared flags", 24'h0, fl);
    $display("test write access done");
    for (int i = 0; i < 21; i++) begin
      if (i == 13) u_src.set_mode(8'h55);
      if (i == 17) u_src.set_mode(8'haa);
      u_src.pulse(21'h1 << i);
      cyc(6);
      chkf("pulse flag", 24'h1 << pos[i], fl);
      clr;
    end
    $display("test event pulses done");
    for (int m = 0; m < 4; m++) begin
      u_src.set_mode(md[m]);
      u_src.pulse(pm[m]);
      cyc(3);
      chkf("mode select", ex[m], fl);
      clr;
    end
    $display("test unit modes done");
    u_src.set_mode(8'hff);
    for (int i = 0; i < 9; i++) begin
      u_src.flip(i);
      cyc(4);
      chkf("level edge", 24'h1 << lpos[i], fl);
      clr;
      u_src.flip(i);
      cyc(4);
      chkf("level return", 24'h0, fl);
    end
    $display("test level sources done");
    fork
      u_src.pulse(21'h400);
      wr(`PIF_OFS_REQ3, 8'h00);
    join
    cyc(8);
    chkf("set beats clear", 24'h001000, fl);
    rd(`PIF_OFS_REQ3, v);
    chk8("held flag read", 8'h10, v);
    $display("test set and clear done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(1);
    chkf("second reset", 24'h0, fl);
    $display("test second reset done");
    wrap_up;
  end

  // watchdog against a hung sequence
  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected end seen hang");
    wrap_up;
  end
endmodule // pif_flag_regs_bench
`default_nettype wire
